// ---- design/ocr_pkg.sv ----
// Shared constants, types and command decoding for the display configuration block
package ocr_pkg;

    // ------------------------------------------------------------
    // Serial command format
    // ------------------------------------------------------------
    localparam logic [4:0] CMD_LAST = 5'h0F;
    localparam logic [7:0] OPC_ROUTE = 8'h9C;
    localparam logic [7:0] OPC_INIT = 8'hB5;
    localparam logic [1:0] ROUTE_PAD = 2'h0;
    localparam logic [3:0] ROW_COUNT = 4'hC;
    localparam logic [4:0] COL_SPLIT = 5'h0C;

    // ------------------------------------------------------------
    // Vertical start step sizes in scan rows
    // ------------------------------------------------------------
    localparam logic [3:0] VSTEP_FINE = 4'h3;
    localparam logic [3:0] VSTEP_COARSE = 4'h9;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_ROUTE = 8'h04;
    localparam logic [7:0] REG_ROWS = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;

    // ------------------------------------------------------------
    // Configuration layout
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OCR_SCH_A = 2'b00,
        OCR_SCH_B = 2'b01,
        OCR_SCH_C = 2'b10
    } ocr_scheme_e;

    // Bit 0 is the clock source select bit, bit 7 the double-frequency mode
    typedef struct packed {
        logic dbl_freq;
        logic mirror;
        logic rev_white;
        ocr_scheme_e scheme;
        logic pin_triple_colour_blanking_set;
        logic vstep9;
        logic clk_ext;
    } ocr_cfg_s;

    localparam ocr_cfg_s CFG_RESET = '{dbl_freq: 1'b0, mirror: 1'b0, rev_white: 1'b0,
        scheme: OCR_SCH_B, pin_triple_colour_blanking_set: 1'b0, vstep9: 1'b0, clk_ext: 1'b0};

    // Two routing bits per row, {route_high_bit, route_low_bit}, row 0 lowest
    typedef logic [23:0] ocr_rows_t;
    localparam ocr_rows_t ROWS_RESET = 24'h000000;

    typedef struct packed {
        ocr_cfg_s cfg;
        ocr_rows_t rows;
    } ocr_ctl_s;

    // Applies one complete 16-bit command word to the control state
    function automatic ocr_ctl_s ocr_apply(ocr_ctl_s c, logic [15:0] w);
        ocr_ctl_s r;
        r = c;
        if (w[15:8] == OPC_ROUTE && w[5:4] == ROUTE_PAD && w[3:0] < ROW_COUNT) begin
            r.rows[{w[3:0], 1'b0} +: 2] = w[7:6];
        end else if (w[15:8] == OPC_INIT) begin
            r.cfg = ocr_cfg_s'(w[7:0]);
        end
        return r;
    endfunction : ocr_apply

endpackage : ocr_pkg

// ---- design/ocr_cfg_if.sv ----
// Carrier of configuration and current-row routing bits between the block's modules
`timescale 1ns/100ps
interface ocr_cfg_if;
    ocr_pkg::ocr_cfg_s cfg;
    logic [1:0] row_bits;
    modport ctl (output cfg, output row_bits);
    modport sink (input cfg, input row_bits);
endinterface : ocr_cfg_if

// ---- design/ocr_dotclk.sv ----
// Dot clock source selection and optional halving of the external clock
`timescale 1ns/100ps
module ocr_dotclk (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Configuration
    ocr_cfg_if.sink cfg_if,
    // Oscillator pins
    input wire logic i_oscillator_input,
    output logic o_oscillator_output,
    // Dot timing
    output logic o_dot_tick
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic half;
        logic tick;
        logic osc_out;
    } ocr_dclk_s;

    ocr_dclk_s q;
    ocr_dclk_s n;

    always_comb begin
        logic rise;
        rise = q.s2 & ~q.s3;
        n = q;
        n.s1 = i_oscillator_input;
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.tick = 1'b0;
        if (cfg_if.cfg.clk_ext) begin
            // External clock: feedback pin driven low
            n.osc_out = 1'b0;
            if (cfg_if.cfg.dbl_freq) begin
                if (rise) begin
                    n.half = ~q.half;
                    n.tick = q.half;
                end
            end else begin
                n.half = 1'b0;
                n.tick = rise;
            end
        end else begin
            // LC tank: inverting feedback, divider setting ignored
            n.osc_out = ~q.s2;
            n.half = 1'b0;
            n.tick = rise;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o_oscillator_output = q.osc_out;
    assign o_dot_tick = q.tick;

endmodule : ocr_dotclk

// ---- design/ocr_route.sv ----
// Character and blanking routing to the colour and auxiliary outputs
`timescale 1ns/100ps
module ocr_route (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Configuration and current row routing bits
    ocr_cfg_if.sink cfg_if,
    // Video from the character generator
    input wire logic i_red_char,
    input wire logic i_green_char,
    input wire logic i_blue_char,
    input wire logic i_char_blank,
    input wire logic i_frame,
    input wire logic i_rev_char,
    input wire logic i_ch2_tag,
    input wire logic i_bg_area,
    input wire logic i_red_blank,
    input wire logic i_green_blank,
    input wire logic i_blue_blank,
    input wire logic [4:0] i_col,
    // Output pins
    output logic o_red_char_out,
    output logic o_green_char_out,
    output logic o_blue_char_out,
    output logic o_common_blank_out,
    output logic o_aux_char_out_one,
    output logic o_aux_blank_out_one,
    output logic o_aux_char_out_two,
    output logic o_aux_blank_out_two
);

    typedef struct packed {
        logic red;
        logic green;
        logic blue;
        logic cblk;
        logic char1;
        logic aux_blank_out_one;
        logic char2;
        logic aux_blank_out_two;
    } ocr_vid_s;

    ocr_vid_s q;
    ocr_vid_s n;

    always_comb begin
        logic any_char;
        logic left;
        logic sel1;
        logic sel2;
        logic vis;
        any_char = i_red_char | i_green_char | i_blue_char;
        left = i_col < ocr_pkg::COL_SPLIT;
        vis = ~i_ch2_tag;
        sel1 = 1'b1;
        sel2 = 1'b0;
        n = q;
        unique case (cfg_if.cfg.scheme)
            ocr_pkg::OCR_SCH_A: begin
                sel1 = ~cfg_if.row_bits[0];
                sel2 = cfg_if.row_bits[0];
            end
            ocr_pkg::OCR_SCH_B: begin
                sel1 = 1'b1;
                sel2 = cfg_if.row_bits[0];
            end
            ocr_pkg::OCR_SCH_C: begin
                unique case (cfg_if.row_bits)
                    2'b00: begin
                        sel1 = 1'b1;
                        sel2 = 1'b0;
                    end
                    2'b01: begin
                        sel1 = left;
                        sel2 = ~left;
                    end
                    2'b10: begin
                        sel1 = ~left;
                        sel2 = left;
                    end
                    2'b11: begin
                        sel1 = 1'b0;
                        sel2 = 1'b1;
                    end
                endcase
            end
            default: begin
                // Unused scheme code behaves as scheme B
                sel1 = 1'b1;
                sel2 = cfg_if.row_bits[0];
            end
        endcase
        // Reversed characters paint the dot area one flat shade, framing off
        n.red = vis & (i_rev_char ? (any_char & cfg_if.cfg.rev_white) : i_red_char);
        n.green = vis & (i_rev_char ? (any_char & cfg_if.cfg.rev_white) : i_green_char);
        n.blue = vis & (i_rev_char ? (any_char & cfg_if.cfg.rev_white) : i_blue_char);
        if (cfg_if.cfg.pin_triple_colour_blanking_set) begin
            // Scheme ignored; pins carry per-colour blanks
            n.cblk = i_blue_blank;
            n.char2 = i_green_blank;
            n.aux_blank_out_two = i_red_blank;
            n.char1 = any_char;
            n.aux_blank_out_one = i_red_blank | i_green_blank | i_blue_blank;
        end else begin
            n.cblk = vis & (i_char_blank | (i_frame & ~i_rev_char));
            n.char1 = sel1 & any_char & vis;
            n.char2 = sel2 & any_char & i_ch2_tag;
            n.aux_blank_out_one = (sel1 & i_char_blank & vis) | (i_bg_area & vis);
            n.aux_blank_out_two = (sel2 & i_char_blank & i_ch2_tag) | (i_bg_area & i_ch2_tag);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o_red_char_out = q.red;
    assign o_green_char_out = q.green;
    assign o_blue_char_out = q.blue;
    assign o_common_blank_out = q.cblk;
    assign o_aux_char_out_one = q.char1;
    assign o_aux_blank_out_one = q.aux_blank_out_one;
    assign o_aux_char_out_two = q.char2;
    assign o_aux_blank_out_two = q.aux_blank_out_two;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    property p_triple_blank;
        cfg_if.cfg.pin_triple_colour_blanking_set |=> q.aux_blank_out_two == $past(i_red_blank) && q.char2 == $past(i_green_blank)
            && q.cblk == $past(i_blue_blank);
    endproperty
    a_triple_blank: assert property (p_triple_blank) else $error("colour blanks misrouted");

    property p_scheme_b_all_rows;
        !cfg_if.cfg.pin_triple_colour_blanking_set && cfg_if.cfg.scheme == ocr_pkg::OCR_SCH_B && i_red_char
            && !i_ch2_tag |=> q.char1;
    endproperty
    a_scheme_b_all_rows: assert property (p_scheme_b_all_rows) else $error("output one lost");

    property p_reverse_shade;
        i_rev_char && i_blue_char && !i_ch2_tag |=> q.red == $past(cfg_if.cfg.rev_white)
            && q.blue == q.red;
    endproperty
    a_reverse_shade: assert property (p_reverse_shade) else $error("reversal shade wrong");

endmodule : ocr_route

// ---- design/ocr_osd_cfg.sv ----
// Top of the display configuration, serial command and output routing block
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
module ocr_osd_cfg (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // AHB-Lite register port
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Serial command pins
    input wire logic i_serial_clk,
    input wire logic i_chip_select_n,
    input wire logic i_serial_data,
    input wire logic i_bit_order_pin,
    input wire logic i_power_on_clear_pin,
    // Oscillator pins
    input wire logic i_oscillator_input,
    output logic o_oscillator_output,
    // Video from the character generator
    input wire logic i_red_char,
    input wire logic i_green_char,
    input wire logic i_blue_char,
    input wire logic i_char_blank,
    input wire logic i_frame,
    input wire logic i_rev_char,
    input wire logic i_ch2_tag,
    input wire logic i_bg_area,
    input wire logic i_red_blank,
    input wire logic i_green_blank,
    input wire logic i_blue_blank,
    input wire logic [3:0] i_row,
    input wire logic [4:0] i_col,
    // Settings to the display core
    output logic o_dot_tick,
    output logic [3:0] o_vstart_step,
    output logic o_blink_en,
    output logic o_mirror_en,
    // Output pins
    output logic o_red_char_out,
    output logic o_green_char_out,
    output logic o_blue_char_out,
    output logic o_common_blank_out,
    output logic o_aux_char_out_one,
    output logic o_aux_blank_out_one,
    output logic o_aux_char_out_two,
    output logic o_aux_blank_out_two
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic cs_s1;
        logic cs_s2;
        logic dat_s1;
        logic dat_s2;
        logic ord_s1;
        logic ord_s2;
        logic pcl_s1;
        logic pcl_s2;
        logic [15:0] shift;
        logic [4:0] cnt;
        logic [15:0] last_cmd;
        logic [7:0] cmd_count;
        ocr_pkg::ocr_ctl_s ctl;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic vstep;
        logic [3:0] step;
        logic blink;
        logic mirror;
    } ocr_top_s;

    // Serial clock and chip select reset to their idle high level so no false edge follows reset
    localparam ocr_top_s TOP_RESET = '{ctl: '{cfg: ocr_pkg::CFG_RESET,
        rows: ocr_pkg::ROWS_RESET}, step: ocr_pkg::VSTEP_FINE, blink: 1'b1, sclk_s1: 1'b1,
        sclk_s2: 1'b1, sclk_s3: 1'b1, cs_s1: 1'b1, cs_s2: 1'b1, default: '0};

    ocr_top_s q;
    ocr_top_s n;
    logic sclk_rise;
    logic cmd_done;

    assign sclk_rise = q.sclk_s2 & ~q.sclk_s3;
    assign cmd_done = sclk_rise & ~q.cs_s2 & (q.cnt == ocr_pkg::CMD_LAST) & ~q.pcl_s2;

    always_comb begin
        logic [15:0] word;
        logic ap_valid;
        word = q.ord_s2 ? {q.shift[14:0], q.dat_s2} : {q.dat_s2, q.shift[15:1]};
        ap_valid = i_hsel & i_hready & i_htrans[1];
        n = q;
        n.sclk_s1 = i_serial_clk;
        n.sclk_s2 = q.sclk_s1;
        n.sclk_s3 = q.sclk_s2;
        n.cs_s1 = i_chip_select_n;
        n.cs_s2 = q.cs_s1;
        n.dat_s1 = i_serial_data;
        n.dat_s2 = q.dat_s1;
        n.ord_s1 = i_bit_order_pin;
        n.ord_s2 = q.ord_s1;
        n.pcl_s1 = i_power_on_clear_pin;
        n.pcl_s2 = q.pcl_s1;

        // Serial shifter
        if (q.cs_s2) begin
            // Deselect throws away a half-shifted word
            n.cnt = 5'h00;
            n.shift = 16'h0000;
        end else if (sclk_rise) begin
            n.shift = word;
            n.cnt = q.cnt + 5'h01;
            if (q.cnt == ocr_pkg::CMD_LAST) begin
                // Counter restarts so commands may follow back to back
                n.cnt = 5'h00;
                n.ctl = ocr_pkg::ocr_apply(q.ctl, word);
                n.last_cmd = word;
                n.cmd_count = q.cmd_count + 8'h01;
            end
        end

        // Register write data phase; lands after any serial command this cycle
        n.wr_pend = 1'b0;
        if (q.wr_pend) begin
            unique case (q.wr_addr)
                ocr_pkg::REG_CFG: n.ctl.cfg = ocr_pkg::ocr_cfg_s'(i_hwdata[7:0]);
                ocr_pkg::REG_ROUTE: n.ctl = ocr_pkg::ocr_apply(n.ctl, i_hwdata[15:0]);
                default: n.ctl = n.ctl;
            endcase
        end

        // Power-on clear overrides serial and register updates to control, count and shifter
        if (q.pcl_s2) begin
            n.ctl = '{cfg: ocr_pkg::CFG_RESET, rows: ocr_pkg::ROWS_RESET};
            n.cnt = 5'h00;
            n.shift = 16'h0000;
        end

        // Register address phase; read data reflects this cycle's updates
        if (ap_valid) begin
            n.wr_pend = i_hwrite;
            n.wr_addr = i_haddr[7:0];
            if (!i_hwrite) begin
                unique case (i_haddr[7:0])
                    ocr_pkg::REG_CFG: n.rdata = {24'h000000, n.ctl.cfg};
                    ocr_pkg::REG_ROUTE: n.rdata = {16'h0000, n.last_cmd};
                    ocr_pkg::REG_ROWS: n.rdata = {8'h00, n.ctl.rows};
                    ocr_pkg::REG_STAT: n.rdata = {19'h00000, n.cnt, n.cmd_count};
                    default: n.rdata = 32'h00000000;
                endcase
            end
        end

        // Settings to the display core
        n.step = n.ctl.cfg.vstep9 ? ocr_pkg::VSTEP_COARSE : ocr_pkg::VSTEP_FINE;
        n.blink = ~n.ctl.cfg.mirror;
        n.mirror = n.ctl.cfg.mirror;
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= TOP_RESET;
        end else begin
            q <= n;
        end
    end

    assign o_hrdata = q.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_vstart_step = q.step;
    assign o_blink_en = q.blink;
    assign o_mirror_en = q.mirror;

    // ------------------------------------------------------------
    // Carrier to the submodules
    // ------------------------------------------------------------
    ocr_cfg_if cfg_bus ();

    assign cfg_bus.cfg = q.ctl.cfg;
    // Rows past the last display row route as all-zero bits
    assign cfg_bus.row_bits = (i_row < ocr_pkg::ROW_COUNT) ?
        q.ctl.rows[{i_row, 1'b0} +: 2] : 2'b00;

    ocr_dotclk u_dotclk (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .cfg_if(cfg_bus),
        .i_oscillator_input(i_oscillator_input),
        .o_oscillator_output(o_oscillator_output),
        .o_dot_tick(o_dot_tick)
    );

    ocr_route u_route (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .cfg_if(cfg_bus),
        .i_red_char(i_red_char),
        .i_green_char(i_green_char),
        .i_blue_char(i_blue_char),
        .i_char_blank(i_char_blank),
        .i_frame(i_frame),
        .i_rev_char(i_rev_char),
        .i_ch2_tag(i_ch2_tag),
        .i_bg_area(i_bg_area),
        .i_red_blank(i_red_blank),
        .i_green_blank(i_green_blank),
        .i_blue_blank(i_blue_blank),
        .i_col(i_col),
        .o_red_char_out(o_red_char_out),
        .o_green_char_out(o_green_char_out),
        .o_blue_char_out(o_blue_char_out),
        .o_common_blank_out(o_common_blank_out),
        .o_aux_char_out_one(o_aux_char_out_one),
        .o_aux_blank_out_one(o_aux_blank_out_one),
        .o_aux_char_out_two(o_aux_char_out_two),
        .o_aux_blank_out_two(o_aux_blank_out_two)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n);

    property p_route_apply;
        cmd_done && !q.wr_pend |=> q.last_cmd[15:8] != ocr_pkg::OPC_ROUTE
            || q.last_cmd[5:4] != ocr_pkg::ROUTE_PAD || q.last_cmd[3:0] >= ocr_pkg::ROW_COUNT
            || q.ctl.rows[{q.last_cmd[3:0], 1'b0} +: 2] == q.last_cmd[7:6];
    endproperty
    a_route_apply: assert property (p_route_apply) else $error("row bits not applied");

    property p_cfg_apply;
        cmd_done && !q.wr_pend |=> q.last_cmd[15:8] != ocr_pkg::OPC_INIT
            || q.ctl.cfg == q.last_cmd[7:0];
    endproperty
    a_cfg_apply: assert property (p_cfg_apply) else $error("config not applied");

    property p_only_whole;
        !cmd_done && !q.wr_pend && !q.pcl_s2 |=> $stable(q.ctl);
    endproperty
    a_only_whole: assert property (p_only_whole) else $error("control changed early");

    property p_deselect_drop;
        q.cs_s2 |=> q.cnt == 5'h00;
    endproperty
    a_deselect_drop: assert property (p_deselect_drop) else $error("count kept");

    property p_bit_count;
        sclk_rise && !q.cs_s2 && !q.pcl_s2 && q.cnt != ocr_pkg::CMD_LAST
            |=> q.cnt == $past(q.cnt) + 5'h01;
    endproperty
    a_bit_count: assert property (p_bit_count) else $error("bit not counted");

    property p_msb_first;
        sclk_rise && !q.cs_s2 && !q.pcl_s2 && q.ord_s2 |=> q.shift[0] == $past(q.dat_s2);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb-first bit misplaced");

    property p_power_clear;
        q.pcl_s2 |=> q.ctl.cfg == ocr_pkg::CFG_RESET ##1 o_vstart_step == ocr_pkg::VSTEP_FINE
            && o_blink_en;
    endproperty
    a_power_clear: assert property (p_power_clear) else $error("defaults not restored");

    property p_lsb_first;
        sclk_rise && !q.cs_s2 && !q.pcl_s2 && !q.ord_s2 |=> q.shift[15] == $past(q.dat_s2);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("lsb-first bit misplaced");

    property p_step_size;
        o_vstart_step == (q.ctl.cfg.vstep9 ? ocr_pkg::VSTEP_COARSE : ocr_pkg::VSTEP_FINE);
    endproperty
    a_step_size: assert property (p_step_size) else $error("start step wrong");

    property p_one_function;
        o_blink_en == !q.ctl.cfg.mirror && o_mirror_en == q.ctl.cfg.mirror;
    endproperty
    a_one_function: assert property (p_one_function) else $error("function pick wrong");

    property p_word_count;
        cmd_done |=> q.cmd_count == $past(q.cmd_count) + 8'h01;
    endproperty
    a_word_count: assert property (p_word_count) else $error("word not counted");

    // Opcode of the word whose last bit is arriving now
    function automatic logic word_is_route();
        return q.ord_s2 ? (q.shift[14:7] == ocr_pkg::OPC_ROUTE)
            : ({q.dat_s2, q.shift[15:9]} == ocr_pkg::OPC_ROUTE);
    endfunction : word_is_route

    c_route_cmd: cover property (cmd_done && word_is_route());
    c_partial_drop: cover property (q.cs_s2 && q.cnt != 5'h00);
    c_scheme_c: cover property (q.ctl.cfg.scheme == ocr_pkg::OCR_SCH_C && q.ctl.rows != 24'h0);
    c_power_clear: cover property (q.pcl_s2);

endmodule : ocr_osd_cfg

// ---- verif/ocr_host_model.sv ----
// Host side model that shifts command words into the serial port
`timescale 1ns/100ps
module ocr_host_model (
    // Clock
    input wire logic i_clk,
    // Serial pins
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdata
);
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_sdata = 1'b0;
    end
    // Fewer than 16 bits leaves a partial word; idle data shows the inverse level
    task automatic send(input logic [15:0] w, input logic msb, input int n);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            o_sclk <= 1'b0;
            o_sdata <= msb ? w[15 - i] : w[i];
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk);
        end
        o_cs_n <= 1'b1;
        o_sdata <= ~o_sdata;
    endtask : send
endmodule : ocr_host_model

// ---- verif/ocr_osd_cfg_tb_top.sv ----
// Self-checking bench for the display configuration block
`timescale 1ns/100ps
module ocr_osd_cfg_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, msb = 1'b0, hready, sclk, cs_n, sd;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [10:0] v = 11'h0;
    logic [3:0] row = 4'h5, vstep;
    logic [4:0] col = 5'h0;
    logic [7:0] vo;
    logic blink, mirror, power_on_clear_pin = 1'b0, osc = 1'b0, tick, osc_o;
    int fails = 0, check_count = 0;
    always #25 clk = ~clk;
    always @(posedge clk) osc <= ~osc;
    ocr_host_model i_ocr_host_model (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdata(sd));
    ocr_osd_cfg i_ocr_osd_cfg (.i_ref_clk(clk), .i_rst_n(rst_n), .i_hsel(1'b1),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(), .i_serial_clk(sclk), .i_chip_select_n(cs_n), .i_serial_data(sd),
        .i_bit_order_pin(msb), .i_power_on_clear_pin(power_on_clear_pin), .i_oscillator_input(osc),
        .o_oscillator_output(osc_o), .i_red_char(v[0]), .i_green_char(v[1]), .i_blue_char(v[2]),
        .i_char_blank(v[3]), .i_frame(v[4]), .i_rev_char(v[5]), .i_ch2_tag(v[6]),
        .i_bg_area(v[7]), .i_red_blank(v[8]), .i_green_blank(v[9]), .i_blue_blank(v[10]),
        .i_row(row), .i_col(col), .o_dot_tick(tick), .o_vstart_step(vstep), .o_blink_en(blink),
        .o_mirror_en(mirror), .o_red_char_out(vo[7]), .o_green_char_out(vo[6]),
        .o_blue_char_out(vo[5]), .o_common_blank_out(vo[4]), .o_aux_char_out_one(vo[3]),
        .o_aux_blank_out_one(vo[2]), .o_aux_char_out_two(vo[1]), .o_aux_blank_out_two(vo[0]));
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Serial word, then enough settle time for sync and apply
    task automatic word(input logic [15:0] w, input int n, input logic [31:0] rows);
        i_ocr_host_model.send(w, msb, n);
        repeat (8) @(posedge clk);
        ahb(1'b0, ocr_pkg::REG_ROWS, 32'h0);
        chk(r, rows);
    endtask : word
    // Video outputs are registered one cycle after the inputs
    task automatic vid(input logic [10:0] val, input logic [4:0] c, input logic [7:0] exp);
        v <= val;
        col <= c;
        repeat (2) @(posedge clk);
        chk({24'h0, vo}, {24'h0, exp});
    endtask : vid
    task automatic dots(input logic [31:0] exp);
        logic [31:0] t;
        t = 32'h0;
        repeat (4) @(posedge clk);
        repeat (40) begin
            @(posedge clk);
            t = t + {31'h0, tick};
        end
        chk(t, exp);
    endtask : dots
    task automatic tally_and_finish;
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        msb <= 1'b1;
        repeat (3) @(posedge clk);
        ahb(1'b0, ocr_pkg::REG_CFG, 32'h0);
        chk(r, 32'h8);
        chk({28'h0, vstep}, 32'h3);
        chk({30'h0, blink, mirror}, 32'h2);
        dots(32'h14);
        ahb(1'b0, 8'h10, 32'h0);
        chk(r, 32'h0);
        word(16'h9C45, 16, 32'h400);
        msb <= 1'b0;
        @(posedge clk);
        word(16'h9C80, 16, 32'h402);
        word(16'h9CC7, 8, 32'h402);
        word(16'h9CCB, 16, 32'hC00402);
        vid(11'h041, 5'h0, 8'h02);
        vid(11'h001, 5'h0, 8'h88);
        chk({31'h0, vo[7]}, 32'h1);
        ahb(1'b1, ocr_pkg::REG_CFG, 32'h52);
        repeat (2) @(posedge clk);
        chk({28'h0, vstep}, 32'h9);
        chk({30'h0, blink, mirror}, 32'h1);
        vid(11'h001, 5'hB, 8'h88);
        vid(11'h001, 5'hC, 8'h80);
        vid(11'h041, 5'hC, 8'h02);
        ahb(1'b1, ocr_pkg::REG_CFG, 32'h62);
        vid(11'h035, 5'h0, 8'hE0);
        vid(11'h049, 5'h0, 8'h03);
        vid(11'h089, 5'h0, 8'h94);
        ahb(1'b1, ocr_pkg::REG_CFG, 32'h4E);
        vid(11'h101, 5'h0, 8'h8D);
        vid(11'h600, 5'h0, 8'h16);
        ahb(1'b1, ocr_pkg::REG_CFG, 32'h81);
        dots(32'h0A);
        chk({31'h0, osc_o}, 32'h0);
        ahb(1'b1, ocr_pkg::REG_CFG, 32'h80);
        dots(32'h14);
        ahb(1'b1, ocr_pkg::REG_CFG, 32'h01);
        dots(32'h14);
        power_on_clear_pin <= 1'b1;
        repeat (4) @(posedge clk);
        power_on_clear_pin <= 1'b0;
        ahb(1'b0, ocr_pkg::REG_CFG, 32'h0);
        chk(r, 32'h8);
        ahb(1'b0, ocr_pkg::REG_ROWS, 32'h0);
        chk(r, 32'h0);
        tally_and_finish();
    end
    initial begin
        #500us;
        fails++;
        tally_and_finish();
    end
endmodule : ocr_osd_cfg_tb_top
